// ---- t16_pkg.sv ----
/*
  Shared constants, types and the mode decoder for the 16-bit timer
  waveform mode and compare-output control block.
  Assumes a single system clock and a synchronous active-high reset.
*/
`default_nettype none

package t16_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0]  T16_OFS_CONTROL_A = 8'h80;
  localparam logic [7:0]  T16_OFS_CONTROL_B = 8'h81;
  localparam logic [7:0]  T16_OFS_COUNT     = 8'h84;
  localparam logic [7:0]  T16_OFS_CAPTURE   = 8'h86;
  localparam logic [7:0]  T16_OFS_COMPARE_A = 8'h88;
  localparam logic [7:0]  T16_OFS_COMPARE_B = 8'h8A;
  localparam logic [7:0]  T16_OFS_STATUS    = 8'h8C;

  // Reset values and writable masks
  localparam logic [7:0]  T16_RST_CONTROL_A  = 8'h00;
  localparam logic [7:0]  T16_RST_CONTROL_B  = 8'h00;
  localparam logic [7:0]  T16_MASK_CONTROL_A = 8'hF3;
  localparam logic [15:0] T16_RST_WORD       = 16'h0000;

  // Field positions
  localparam int T16_POS_WAVE_HI  = 3;
  localparam int T16_POS_OVF_FLAG = 0;
  localparam int T16_POS_DIR      = 1;

  // Count limits
  localparam logic [15:0] T16_BOTTOM  = 16'h0000;
  localparam logic [15:0] T16_MAX     = 16'hFFFF;
  localparam logic [15:0] T16_TOP_8B  = 16'h00FF;
  localparam logic [15:0] T16_TOP_9B  = 16'h01FF;
  localparam logic [15:0] T16_TOP_10B = 16'h03FF;

  // Modes that allow channel A toggle in PWM classes
  localparam logic [3:0]  T16_MODE_DUAL_TOG_CAP = 4'h9;
  localparam logic [3:0]  T16_MODE_DUAL_TOG_CMP = 4'hB;
  localparam logic [3:0]  T16_MODE_FAST_TOG_CAP = 4'hE;
  localparam logic [3:0]  T16_MODE_FAST_TOG_CMP = 4'hF;

  typedef enum logic [1:0] {
    T16_CLS_NONPWM = 2'b00,
    T16_CLS_FAST   = 2'b01,
    T16_CLS_DUAL   = 2'b10
  } t16_class_t;

  typedef enum logic [1:0] {
    T16_UPD_IMMEDIATE = 2'b00,
    T16_UPD_AT_TOP    = 2'b01,
    T16_UPD_AT_BOTTOM = 2'b10
  } t16_upd_t;

  typedef enum logic [1:0] {
    T16_OVF_AT_MAX    = 2'b00,
    T16_OVF_AT_TOP    = 2'b01,
    T16_OVF_AT_BOTTOM = 2'b10
  } t16_ovf_t;

  typedef enum logic [2:0] {
    T16_TOP_MAX     = 3'b000,
    T16_TOP_FIX8    = 3'b001,
    T16_TOP_FIX9    = 3'b010,
    T16_TOP_FIX10   = 3'b011,
    T16_TOP_CAPTURE = 3'b100,
    T16_TOP_CMP_A   = 3'b101
  } t16_top_src_t;

  typedef enum logic {
    T16_DIR_UP   = 1'b0,
    T16_DIR_DOWN = 1'b1
  } t16_dir_t;

  typedef struct packed {
    t16_class_t   cls;
    t16_upd_t     upd;
    t16_ovf_t     ovf;
    t16_top_src_t top;
  } t16_mode_t;

  typedef struct packed {
    logic [1:0] out_mode_a;
    logic [1:0] out_mode_b;
    logic [1:0] rsvd;
    logic [1:0] wave_lo;
  } t16_ctrl_a_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } t16_bus_req_t;

  // Mode 13 is reserved and falls back to plain counting
  function automatic t16_mode_t t16_decode(input logic [3:0] mode);
    t16_mode_t m;
    m = '{T16_CLS_NONPWM, T16_UPD_IMMEDIATE, T16_OVF_AT_MAX, T16_TOP_MAX};
    case (mode)
      4'h1: m = '{T16_CLS_DUAL, T16_UPD_AT_TOP, T16_OVF_AT_BOTTOM, T16_TOP_FIX8};
      4'h2: m = '{T16_CLS_DUAL, T16_UPD_AT_TOP, T16_OVF_AT_BOTTOM, T16_TOP_FIX9};
      4'h3: m = '{T16_CLS_DUAL, T16_UPD_AT_TOP, T16_OVF_AT_BOTTOM, T16_TOP_FIX10};
      4'h4: m = '{T16_CLS_NONPWM, T16_UPD_IMMEDIATE, T16_OVF_AT_MAX, T16_TOP_CMP_A};
      4'h5: m = '{T16_CLS_FAST, T16_UPD_AT_BOTTOM, T16_OVF_AT_TOP, T16_TOP_FIX8};
      4'h6: m = '{T16_CLS_FAST, T16_UPD_AT_BOTTOM, T16_OVF_AT_TOP, T16_TOP_FIX9};
      4'h7: m = '{T16_CLS_FAST, T16_UPD_AT_BOTTOM, T16_OVF_AT_TOP, T16_TOP_FIX10};
      4'h8: m = '{T16_CLS_DUAL, T16_UPD_AT_BOTTOM, T16_OVF_AT_BOTTOM, T16_TOP_CAPTURE};
      4'h9: m = '{T16_CLS_DUAL, T16_UPD_AT_BOTTOM, T16_OVF_AT_BOTTOM, T16_TOP_CMP_A};
      4'hA: m = '{T16_CLS_DUAL, T16_UPD_AT_TOP, T16_OVF_AT_BOTTOM, T16_TOP_CAPTURE};
      4'hB: m = '{T16_CLS_DUAL, T16_UPD_AT_TOP, T16_OVF_AT_BOTTOM, T16_TOP_CMP_A};
      4'hC: m = '{T16_CLS_NONPWM, T16_UPD_IMMEDIATE, T16_OVF_AT_MAX, T16_TOP_CAPTURE};
      4'hE: m = '{T16_CLS_FAST, T16_UPD_AT_BOTTOM, T16_OVF_AT_TOP, T16_TOP_CAPTURE};
      4'hF: m = '{T16_CLS_FAST, T16_UPD_AT_BOTTOM, T16_OVF_AT_TOP, T16_TOP_CMP_A};
      default: m = '{T16_CLS_NONPWM, T16_UPD_IMMEDIATE, T16_OVF_AT_MAX, T16_TOP_MAX};
    endcase
    return m;
  endfunction

endpackage

`default_nettype wire

// ---- t16_wave_ctrl.sv ----
/*
  16-bit timer core with waveform mode decode, double-buffered compare
  registers, overflow flag and two compare-output pin channels.
  Assumes a plain register port on the same clock; port data and
  direction inputs come from the same-clock port logic.
*/
`timescale 1ns/1ps
`default_nettype none

module t16_wave_ctrl (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rst,
  input  wire t16_pkg::t16_bus_req_t i_bus,
  output logic [15:0]                o_rdata,
  input  wire logic                  i_port_data_a,
  input  wire logic                  i_port_dir_a,
  input  wire logic                  i_port_data_b,
  input  wire logic                  i_port_dir_b,
  output logic                       o_pin_a_out,
  output logic                       o_pin_a_oe,
  output logic                       o_pin_b_out,
  output logic                       o_pin_b_oe,
  output logic                       o_overflow_flag
);

  t16_pkg::t16_ctrl_a_t ctrl_a;
  t16_pkg::t16_ctrl_a_t next_ctrl_a;
  logic [1:0]           wave_hi;
  logic [1:0]           next_wave_hi;
  logic [15:0]          capture_value;
  logic [15:0]          next_capture_value;
  logic [15:0]          buf_cmp [2];
  logic [15:0]          next_buf_cmp [2];
  logic [15:0]          cmp_act [2];
  logic [15:0]          next_cmp_act [2];
  logic [15:0]          count_value;
  logic [15:0]          next_count_value;
  t16_pkg::t16_dir_t    dir;
  t16_pkg::t16_dir_t    next_dir;
  logic                 overflow_flag;
  logic                 next_overflow_flag;
  logic [15:0]          rdata;
  logic [15:0]          next_rdata;
  logic [3:0]           mode;
  t16_pkg::t16_mode_t   mdec;
  logic [15:0]          top;
  logic                 at_top;
  logic                 at_bottom;
  logic                 ovf_event;
  logic                 load_cmp;
  logic                 wave [2];
  logic                 next_wave [2];
  logic                 pin_out [2];
  logic                 next_pin_out [2];
  logic                 pin_oe [2];
  logic                 next_pin_oe [2];
  logic                 port_data [2];
  logic                 port_dir [2];

  function automatic logic wr_hit(input t16_pkg::t16_bus_req_t req, input logic [7:0] ofs);
    return req.wr && (req.addr == ofs);
  endfunction

  function automatic logic toggle_ok(input t16_pkg::t16_class_t cls, input logic [3:0] md, input int ch);
    logic ok;
    ok = 1'b0;
    case (cls)
      t16_pkg::T16_CLS_NONPWM: ok = 1'b1;
      t16_pkg::T16_CLS_FAST:   ok = (ch == 0) && ((md == t16_pkg::T16_MODE_FAST_TOG_CAP) ||
                                                  (md == t16_pkg::T16_MODE_FAST_TOG_CMP));
      t16_pkg::T16_CLS_DUAL:   ok = (ch == 0) && ((md == t16_pkg::T16_MODE_DUAL_TOG_CAP) ||
                                                  (md == t16_pkg::T16_MODE_DUAL_TOG_CMP));
      default:                 ok = 1'b0;
    endcase
    return ok;
  endfunction

  assign port_data[0] = i_port_data_a;
  assign port_data[1] = i_port_data_b;
  assign port_dir[0]  = i_port_dir_a;
  assign port_dir[1]  = i_port_dir_b;

  // Mode decode and count landmarks
  always_comb begin
    mode = {wave_hi, ctrl_a.wave_lo};
    mdec = t16_pkg::t16_decode(mode);
    case (mdec.top)
      t16_pkg::T16_TOP_FIX8:    top = t16_pkg::T16_TOP_8B;
      t16_pkg::T16_TOP_FIX9:    top = t16_pkg::T16_TOP_9B;
      t16_pkg::T16_TOP_FIX10:   top = t16_pkg::T16_TOP_10B;
      t16_pkg::T16_TOP_CAPTURE: top = capture_value;
      t16_pkg::T16_TOP_CMP_A:   top = cmp_act[0];
      default:                  top = t16_pkg::T16_MAX;
    endcase
    at_top    = (count_value == top);
    at_bottom = (count_value == t16_pkg::T16_BOTTOM);
    case (mdec.ovf)
      t16_pkg::T16_OVF_AT_TOP:    ovf_event = at_top;
      t16_pkg::T16_OVF_AT_BOTTOM: ovf_event = at_bottom && (dir == t16_pkg::T16_DIR_DOWN);
      default:                    ovf_event = (count_value == t16_pkg::T16_MAX);
    endcase
    case (mdec.upd)
      t16_pkg::T16_UPD_AT_TOP:    load_cmp = at_top;
      t16_pkg::T16_UPD_AT_BOTTOM: load_cmp = at_bottom;
      default:                    load_cmp = 1'b1;
    endcase
  end

  // Register file, counter and compare buffering
  always_comb begin
    next_ctrl_a        = ctrl_a;
    next_wave_hi       = wave_hi;
    next_capture_value = capture_value;
    next_buf_cmp       = buf_cmp;
    next_cmp_act       = cmp_act;
    next_dir           = dir;
    next_rdata         = rdata;
    if (wr_hit(i_bus, t16_pkg::T16_OFS_CONTROL_A)) begin
      next_ctrl_a = t16_pkg::t16_ctrl_a_t'(i_bus.wdata[7:0] & t16_pkg::T16_MASK_CONTROL_A);
    end
    if (wr_hit(i_bus, t16_pkg::T16_OFS_CONTROL_B)) begin
      next_wave_hi = i_bus.wdata[t16_pkg::T16_POS_WAVE_HI +: 2];
    end
    if (wr_hit(i_bus, t16_pkg::T16_OFS_CAPTURE)) begin
      next_capture_value = i_bus.wdata;
    end
    if (wr_hit(i_bus, t16_pkg::T16_OFS_COMPARE_A)) begin
      next_buf_cmp[0] = i_bus.wdata;
    end
    if (wr_hit(i_bus, t16_pkg::T16_OFS_COMPARE_B)) begin
      next_buf_cmp[1] = i_bus.wdata;
    end
    // Immediate modes copy every cycle, so a write lands one cycle later
    if (load_cmp) begin
      next_cmp_act = buf_cmp;
    end
    if (mdec.cls == t16_pkg::T16_CLS_DUAL) begin
      if (dir == t16_pkg::T16_DIR_UP) begin
        if (count_value >= top) begin
          next_dir         = t16_pkg::T16_DIR_DOWN;
          next_count_value = count_value - 16'h0001;
        end else begin
          next_count_value = count_value + 16'h0001;
        end
      end else if (at_bottom) begin
        next_dir         = t16_pkg::T16_DIR_UP;
        next_count_value = count_value + 16'h0001;
      end else begin
        next_count_value = count_value - 16'h0001;
      end
    end else begin
      next_dir = t16_pkg::T16_DIR_UP;
      // A top below the count runs on through max and wraps
      next_count_value = at_top ? t16_pkg::T16_BOTTOM : count_value + 16'h0001;
    end
    if (wr_hit(i_bus, t16_pkg::T16_OFS_COUNT)) begin
      next_count_value = i_bus.wdata;
    end
    // Set wins over a clear in the same cycle
    next_overflow_flag = ovf_event || (overflow_flag &&
                         !(wr_hit(i_bus, t16_pkg::T16_OFS_STATUS) && i_bus.wdata[t16_pkg::T16_POS_OVF_FLAG]));
    if (i_bus.rd) begin
      case (i_bus.addr)
        t16_pkg::T16_OFS_CONTROL_A: next_rdata = {8'h00, ctrl_a};
        t16_pkg::T16_OFS_CONTROL_B: next_rdata = {11'h000, wave_hi, 3'h0};
        t16_pkg::T16_OFS_COUNT:     next_rdata = count_value;
        t16_pkg::T16_OFS_CAPTURE:   next_rdata = capture_value;
        t16_pkg::T16_OFS_COMPARE_A: next_rdata = buf_cmp[0];
        t16_pkg::T16_OFS_COMPARE_B: next_rdata = buf_cmp[1];
        t16_pkg::T16_OFS_STATUS:    next_rdata = {14'h0000, dir, overflow_flag};
        default:                    next_rdata = 16'h0000;
      endcase
    end else begin
      next_rdata = 16'h0000;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ctrl_a        <= t16_pkg::t16_ctrl_a_t'(t16_pkg::T16_RST_CONTROL_A);
      wave_hi       <= t16_pkg::T16_RST_CONTROL_B[t16_pkg::T16_POS_WAVE_HI +: 2];
      capture_value <= t16_pkg::T16_RST_WORD;
      buf_cmp[0]    <= t16_pkg::T16_RST_WORD;
      buf_cmp[1]    <= t16_pkg::T16_RST_WORD;
      cmp_act[0]    <= t16_pkg::T16_RST_WORD;
      cmp_act[1]    <= t16_pkg::T16_RST_WORD;
      count_value   <= t16_pkg::T16_RST_WORD;
      dir           <= t16_pkg::T16_DIR_UP;
      overflow_flag <= 1'b0;
      rdata         <= 16'h0000;
    end else begin
      ctrl_a        <= next_ctrl_a;
      wave_hi       <= next_wave_hi;
      capture_value <= next_capture_value;
      buf_cmp       <= next_buf_cmp;
      cmp_act       <= next_cmp_act;
      count_value   <= next_count_value;
      dir           <= next_dir;
      overflow_flag <= next_overflow_flag;
      rdata         <= next_rdata;
    end
  end

  // Compare-output channels: 0 is A, 1 is B
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic [1:0] om;
    logic       match;
    logic       tog;
    logic       connected;

    always_comb begin
      om        = (ch == 0) ? ctrl_a.out_mode_a : ctrl_a.out_mode_b;
      match     = (count_value == cmp_act[ch]);
      tog       = (om == 2'b01) && toggle_ok(mdec.cls, mode, ch);
      connected = om[1] || tog;
      next_wave[ch] = wave[ch];
      case (mdec.cls)
        t16_pkg::T16_CLS_NONPWM: begin
          if (match && tog) begin
            next_wave[ch] = ~wave[ch];
          end else if (match && om[1]) begin
            next_wave[ch] = om[0];
          end
        end
        t16_pkg::T16_CLS_FAST: begin
          if (tog && match) begin
            next_wave[ch] = ~wave[ch];
          end else if (om[1]) begin
            if (at_bottom) begin
              next_wave[ch] = ~om[0];
            end
            // Match at bottom wins, so a compare of zero holds the output at the match level
            if (match && (cmp_act[ch] != top)) begin
              next_wave[ch] = om[0];
            end
          end
        end
        t16_pkg::T16_CLS_DUAL: begin
          if (tog && match) begin
            next_wave[ch] = ~wave[ch];
          end else if (om[1] && match) begin
            if (cmp_act[ch] == t16_pkg::T16_BOTTOM) begin
              next_wave[ch] = om[0];
            end else if (cmp_act[ch] == top) begin
              next_wave[ch] = ~om[0];
            end else begin
              next_wave[ch] = (dir == t16_pkg::T16_DIR_UP) ? om[0] : ~om[0];
            end
          end
        end
        default: next_wave[ch] = wave[ch];
      endcase
      next_pin_out[ch] = connected ? wave[ch] : port_data[ch];
      next_pin_oe[ch]  = port_dir[ch];
    end

    always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
        wave[ch]    <= 1'b0;
        pin_out[ch] <= 1'b0;
        pin_oe[ch]  <= 1'b0;
      end else begin
        wave[ch]    <= next_wave[ch];
        pin_out[ch] <= next_pin_out[ch];
        pin_oe[ch]  <= next_pin_oe[ch];
      end
    end
  end

  assign o_rdata         = rdata;
  assign o_pin_a_out     = pin_out[0];
  assign o_pin_a_oe      = pin_oe[0];
  assign o_pin_b_out     = pin_out[1];
  assign o_pin_b_oe      = pin_oe[1];
  assign o_overflow_flag = overflow_flag;

endmodule

`default_nettype wire

// ---- t16_wave_ctrl_assertions.sv ----
/*
  Port checker for the timer waveform control block.
  Assumes one clock and a synchronous active-high reset; bound to the top.
*/
`timescale 1ns/1ps
`default_nettype none

module t16_wave_ctrl_chk (
  input wire logic                  i_clk_sys,
  input wire logic                  i_rst,
  input wire t16_pkg::t16_bus_req_t i_bus,
  input wire logic [15:0]           o_rdata,
  input wire logic                  i_port_data_a,
  input wire logic                  i_port_dir_a,
  input wire logic                  i_port_data_b,
  input wire logic                  i_port_dir_b,
  input wire logic                  o_pin_a_out,
  input wire logic                  o_pin_a_oe,
  input wire logic                  o_pin_b_out,
  input wire logic                  o_pin_b_oe,
  input wire logic                  o_overflow_flag
);
  // Shadow of both output-mode fields, kept from bus writes alone
  logic [3:0] com_shadow;
  logic [3:0] next_com_shadow;
  logic [1:0] lo_shadow;
  logic [1:0] next_lo_shadow;

  always_comb begin
    next_com_shadow = com_shadow;
    next_lo_shadow  = lo_shadow;
    if (i_bus.wr && i_bus.addr == t16_pkg::T16_OFS_CONTROL_A) begin
      next_com_shadow = i_bus.wdata[7:4];
      next_lo_shadow  = i_bus.wdata[1:0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      com_shadow <= 4'h0;
      lo_shadow  <= 2'h0;
    end else begin
      com_shadow <= next_com_shadow;
      lo_shadow  <= next_lo_shadow;
    end
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence rd_ctrl_a_s;
    i_bus.rd && i_bus.addr == t16_pkg::T16_OFS_CONTROL_A;
  endsequence
  sequence rd_ctrl_b_s;
    i_bus.rd && i_bus.addr == t16_pkg::T16_OFS_CONTROL_B;
  endsequence
  sequence rd_status_s;
    i_bus.rd && i_bus.addr == t16_pkg::T16_OFS_STATUS;
  endsequence
  sequence flag_kept_s;
    o_overflow_flag && !(i_bus.wr && i_bus.addr == t16_pkg::T16_OFS_STATUS && i_bus.wdata[0]);
  endsequence

  oe_a_follow_a: assert property (!$past(i_rst) |-> o_pin_a_oe == $past(i_port_dir_a))
    else $error("pin A enable does not follow direction bit");
  oe_b_follow_a: assert property (!$past(i_rst) |-> o_pin_b_oe == $past(i_port_dir_b))
    else $error("pin B enable does not follow direction bit");
  rdata_idle_a: assert property (!$past(i_rst) && !$past(i_bus.rd) |-> o_rdata == 16'h0000)
    else $error("read data not zero outside read answer");
  ctrl_a_read_a: assert property (rd_ctrl_a_s |=> o_rdata == {8'h00, $past(com_shadow), 2'h0, $past(lo_shadow)})
    else $error("control A read back wrong");
  ctrl_b_read_a: assert property (rd_ctrl_b_s |=> o_rdata[15:5] == 11'h000 && o_rdata[2:0] == 3'h0)
    else $error("control B read back holds stray bits");
  pin_a_port_a: assert property (!$past(i_rst) && $past(com_shadow[3:2]) == 2'h0
                                 |-> o_pin_a_out == $past(i_port_data_a))
    else $error("pin A not under port control while disconnected");
  pin_b_port_a: assert property (!$past(i_rst) && $past(com_shadow[1:0]) == 2'h0
                                 |-> o_pin_b_out == $past(i_port_data_b))
    else $error("pin B not under port control while disconnected");
  flag_sticky_a: assert property (flag_kept_s |=> o_overflow_flag)
    else $error("overflow flag dropped without a clear");
  status_read_a: assert property (rd_status_s |=> o_rdata[0] == $past(o_overflow_flag))
    else $error("status read does not show overflow flag");
endmodule

bind t16_wave_ctrl t16_wave_ctrl_chk u_chk (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata),
  .i_port_data_a(i_port_data_a), .i_port_dir_a(i_port_dir_a),
  .i_port_data_b(i_port_data_b), .i_port_dir_b(i_port_dir_b),
  .o_pin_a_out(o_pin_a_out), .o_pin_a_oe(o_pin_a_oe),
  .o_pin_b_out(o_pin_b_out), .o_pin_b_oe(o_pin_b_oe), .o_overflow_flag(o_overflow_flag)
);

`default_nettype wire

// ---- timer16_waveform_mode_control_tb.sv ----
/*
  Self-checking bench for the timer waveform control block.
  Assumes the package and design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module timer16_waveform_mode_control_tb;
  typedef struct packed {
    logic [3:0]  mode;
    logic [1:0]  com;
    logic [15:0] cap;
    logic [15:0] cmp;
    logic [15:0] period;
  } t16_row_t;

  logic                  i_clk_sys;
  logic                  i_rst;
  t16_pkg::t16_bus_req_t i_bus;
  logic [15:0]           o_rdata;
  logic                  i_port_data_a, i_port_dir_a, i_port_data_b, i_port_dir_b;
  logic                  o_pin_a_out, o_pin_a_oe, o_pin_b_out, o_pin_b_oe, o_overflow_flag;
  int                    n_errors;
  int                    cmp_count;
  int                    n;
  logic [15:0]           rd;
  // Rise-to-rise period: toggle 2*(top+1), dual toggle 4*top, fast top+1, dual 2*top
  t16_row_t rows [16] = '{
    '{4'h4, 2'h1, 16'h0000, 16'h0007, 16'h0010}, '{4'hC, 2'h1, 16'h0009, 16'h0009, 16'h0014},
    '{4'hF, 2'h1, 16'h0000, 16'h0005, 16'h000C}, '{4'hE, 2'h1, 16'h000B, 16'h0003, 16'h0018},
    '{4'h9, 2'h1, 16'h0000, 16'h0006, 16'h0018}, '{4'hB, 2'h1, 16'h0000, 16'h0005, 16'h0014},
    '{4'h5, 2'h2, 16'h0000, 16'h0010, 16'h0100}, '{4'h6, 2'h2, 16'h0000, 16'h0010, 16'h0200},
    '{4'h7, 2'h2, 16'h0000, 16'h0010, 16'h0400}, '{4'h1, 2'h2, 16'h0000, 16'h0010, 16'h01FE},
    '{4'h2, 2'h2, 16'h0000, 16'h0010, 16'h03FE}, '{4'h3, 2'h2, 16'h0000, 16'h0010, 16'h07FE},
    '{4'h8, 2'h2, 16'h000C, 16'h0004, 16'h0018}, '{4'hA, 2'h2, 16'h000E, 16'h0004, 16'h001C},
    '{4'h5, 2'h3, 16'h0000, 16'h0010, 16'h0100}, '{4'h1, 2'h3, 16'h0000, 16'h0010, 16'h01FE}
  };
  // High time after a rise: half period when toggling, else set by compare value and polarity
  logic [15:0] highs [16] = '{
    16'h0008, 16'h000A, 16'h0006, 16'h000C, 16'h000C, 16'h000A, 16'h0010, 16'h0010,
    16'h0010, 16'h0020, 16'h0020, 16'h0020, 16'h0008, 16'h0008, 16'h00F0, 16'h01DE
  };

  t16_wave_ctrl dut (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_port_data_a(i_port_data_a), .i_port_dir_a(i_port_dir_a),
    .i_port_data_b(i_port_data_b), .i_port_dir_b(i_port_dir_b),
    .o_pin_a_out(o_pin_a_out), .o_pin_a_oe(o_pin_a_oe),
    .o_pin_b_out(o_pin_b_out), .o_pin_b_oe(o_pin_b_oe), .o_overflow_flag(o_overflow_flag)
  );

  always #2.5 i_clk_sys = ~i_clk_sys;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t value mismatch got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Strobe drops one edge later, so the next call never raises it in the same step
  task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    i_bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_clk_sys);
    i_bus <= '{a, d, 1'b0, 1'b0};
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_clk_sys);
    i_bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge i_clk_sys);
    i_bus <= '{a, 16'h0000, 1'b0, 1'b0};
    #1 d = o_rdata;
  endtask

  // Count restarts at zero last, so the old count cannot run past a lower top
  task automatic cfg(input logic [3:0] m, input logic [1:0] ca, cb, input logic [15:0] cap, cmp);
    bus_wr(t16_pkg::T16_OFS_CAPTURE, cap);
    bus_wr(t16_pkg::T16_OFS_COMPARE_A, cmp);
    bus_wr(t16_pkg::T16_OFS_CONTROL_B, {11'h000, m[3:2], 3'h0});
    bus_wr(t16_pkg::T16_OFS_CONTROL_A, {8'h00, ca, cb, 2'h0, m[1:0]});
    bus_wr(t16_pkg::T16_OFS_COUNT, 16'h0000);
  endtask

  task automatic next_rise(output int cnt);
    logic p;
    cnt = 0;
    p = 1'b1;
    repeat (5000) begin
      @(posedge i_clk_sys);
      cnt++;
      if (p === 1'b0 && o_pin_a_out === 1'b1) return;
      p = o_pin_a_out;
    end
    cnt = -1;
  endtask

  initial begin
    repeat (60000) @(posedge i_clk_sys);
    n_errors++;
    final_report();
  end

  initial begin
    i_clk_sys = 1'b0;
    i_rst = 1'b1;
    i_bus = '{8'h00, 16'h0000, 1'b0, 1'b0};
    {i_port_data_a, i_port_dir_a, i_port_data_b, i_port_dir_b} = 4'h5;
    repeat (8) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    bus_rd(t16_pkg::T16_OFS_CONTROL_A, rd); chk(rd, 16'h0000);
    bus_rd(t16_pkg::T16_OFS_CONTROL_B, rd); chk(rd, 16'h0000);
    // Write then read back to back, no idle cycle between
    @(posedge i_clk_sys);
    i_bus <= '{t16_pkg::T16_OFS_CONTROL_A, 16'h00FF, 1'b1, 1'b0};
    @(posedge i_clk_sys);
    i_bus <= '{t16_pkg::T16_OFS_CONTROL_A, 16'h0000, 1'b0, 1'b1};
    @(posedge i_clk_sys);
    i_bus <= '{t16_pkg::T16_OFS_CONTROL_A, 16'h0000, 1'b0, 1'b0};
    #1 chk(o_rdata, 16'h00F3);
    bus_wr(t16_pkg::T16_OFS_CONTROL_B, 16'h00FF);
    bus_rd(t16_pkg::T16_OFS_CONTROL_B, rd); chk(rd, 16'h0018);
    bus_wr(8'h90, 16'h00FF);
    bus_rd(8'h90, rd); chk(rd, 16'h0000);
    foreach (rows[i]) begin
      cfg(rows[i].mode, rows[i].com, 2'h0, rows[i].cap, rows[i].cmp);
      next_rise(n);
      next_rise(n);
      next_rise(n);
      chk(16'(n), rows[i].period);
      // Period alone cannot tell inverted from non-inverted output
      n = 0;
      while (o_pin_a_out === 1'b1 && n < 5000) begin
        @(posedge i_clk_sys);
        n++;
      end
      chk(16'(n), highs[i]);
    end
    // Toggle code where it is not allowed leaves the pin with the port
    foreach (rows[i]) if (i < 4) begin
      cfg(rows[2 * i + 6].mode, 2'h1, 2'h1, 16'h0020, 16'h0010);
      i_port_data_a <= i[0];
      i_port_data_b <= i[0];
      repeat (4) @(posedge i_clk_sys);
      chk(o_pin_b_out, i[0]);
      chk(o_pin_a_out, i[0]);
    end
    cfg(4'hF, 2'h1, 2'h1, 16'h0000, 16'h0005);
    repeat (4) @(posedge i_clk_sys);
    chk(o_pin_b_out, i_port_data_b);
    for (int c = 2; c < 4; c++) begin
      cfg(4'h4, 2'h0, c[1:0], 16'h0000, 16'h0007);
      bus_wr(t16_pkg::T16_OFS_COMPARE_B, 16'h0003);
      i_port_data_b <= ~c[0];
      repeat (30) @(posedge i_clk_sys);
      chk(o_pin_b_out, c[0]);
    end
    // Extreme compare values hold the pin at one level
    for (int s = 0; s < 3; s++) begin
      cfg((s == 2) ? 4'h5 : 4'h1, 2'h2, 2'h0, 16'h0000, (s == 0) ? 16'h0000 : 16'h00FF);
      repeat (1200) @(posedge i_clk_sys);
      n = 0;
      repeat (600) begin
        @(posedge i_clk_sys);
        if (o_pin_a_out !== (s != 0)) n++;
      end
      chk(16'(n), 16'h0000);
    end
    for (int m = 0; m < 2; m++) begin
      cfg(m ? 4'hD : 4'h0, 2'h0, 2'h0, 16'h0000, 16'h0000);
      bus_wr(t16_pkg::T16_OFS_STATUS, 16'h0001);
      bus_wr(t16_pkg::T16_OFS_COUNT, 16'hFFF0);
      chk(o_overflow_flag, 1'b0);
      n = 0;
      while (o_overflow_flag !== 1'b1 && n < 40) begin
        @(posedge i_clk_sys);
        n++;
      end
      bus_rd(t16_pkg::T16_OFS_STATUS, rd); chk(rd[0], 1'b1);
    end
    i_port_dir_a <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    chk(o_pin_a_oe, 1'b0);
    // Reset in mid-run drops the sticky flag and the control fields
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    chk(o_overflow_flag, 1'b0);
    bus_rd(t16_pkg::T16_OFS_CONTROL_A, rd); chk(rd, 16'h0000);
    final_report();
  end
endmodule

`default_nettype wire
